// *** verilog/dtec_pkg.sv ***
/*
 * Constants and types shared by the dual timer/event counter.
 * Assumes an APB slave with 32-bit data; each register index maps to byte address index*4.
 */
package dtec_pkg;

	localparam int DTEC_ADDR_W = 12;
	localparam int DTEC_DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] DTEC_IDX_CONTROL = 8'h88;
	localparam logic [7:0] DTEC_IDX_MODE = 8'h89;
	localparam logic [7:0] DTEC_IDX_STATUS = 8'h8a;
	localparam logic [7:0] DTEC_IDX_MASK = 8'h8b;
	localparam logic [7:0] DTEC_IDX_LOW0 = 8'h8c;
	localparam logic [7:0] DTEC_IDX_HIGH0 = 8'h8d;
	localparam logic [7:0] DTEC_IDX_LOW1 = 8'h8e;
	localparam logic [7:0] DTEC_IDX_HIGH1 = 8'h8f;

	// Mode register: each unit owns a four-bit field, timer 1 above timer 0.
	localparam int DTEC_MODE_UNIT_W = 4;
	localparam int DTEC_FLD_GATE = 3;
	localparam int DTEC_FLD_SOURCE = 2;
	localparam int DTEC_FLD_MODE = 0;

	// Control register: run bits, then overflow toggle enables.
	localparam int DTEC_CTRL_RUN = 0;
	localparam int DTEC_CTRL_TOGGLE = 2;

	localparam logic [7:0] DTEC_MODE_RESET = 8'h00;
	localparam logic [3:0] DTEC_CTRL_RESET = 4'h0;
	localparam logic [7:0] DTEC_BYTE_ONES = 8'hff;
	localparam logic [12:0] DTEC_PRESCALED_ONES = 13'h1fff;

	// One machine cycle is six clock periods.
	localparam int DTEC_CLOCKS_PER_MCYCLE = 6;

	typedef enum logic [1:0] {
		DTEC_MODE_PRESCALED13 = 2'b00,
		DTEC_MODE_CASCADED16 = 2'b01,
		DTEC_MODE_AUTO_RELOAD = 2'b10,
		DTEC_MODE_SPLIT = 2'b11
	} dtec_mode_t;

	typedef struct packed {
		logic [7:0] count_high_byte;
		logic [7:0] count_low_byte;
	} dtec_count_t;

	typedef struct packed {
		logic ovf;
		dtec_count_t count;
	} dtec_step_t;

endpackage

// *** verilog/dtec_timer.sv ***
/*
 * Dual timer/event counter with an APB register slave and a level interrupt.
 * All counting logic, the per-mode counting step included, lives in this module.
 * Assumes count and gate pins are synchronous to clock and that the count pins'
 * external wire resolves output enable and level outside this module.
 * Assumes the bus master holds each request until pready, as APB requires.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// Functional notes
// - In timer function a unit counts once per machine cycle of six clocks.
// - In counter function the count pin is sampled each machine cycle and a high-then-low pair counts one.
// - The count raised by a detected falling edge is visible in the machine cycle after detection.
// - Edge recognition spans two machine cycles, so events count at most at one twelfth of the clock rate.
// - The source bit of each unit picks machine cycles when clear and count pin edges when set.
// - The two-bit mode field sits at bits 5:4 for timer 1 and bits 1:0 for timer 0.
// - Mode 00 is 13-bit prescaled, 01 is 16-bit, 10 is 8-bit auto-reload and 11 is split.
// - Modes 00 to 10 behave the same for both units and only mode 11 differs.
// - With the gate bit set a unit counts only while its gate pin is high and its run bit is set.
// - Each unit may toggle its count pin on every overflow.
// - Mode 00 counts on the high byte and the low five bits of the low byte and flags rollover from all ones.
// - Mode 10 counts the low byte and on overflow flags it and reloads from the unchanged high byte.
// - Timer 1 stops in mode 11, while timer 0 splits into a low byte and a machine-cycle high byte using timer 1's run bit and flag.
// - With toggling enabled the count pin output is one until the first overflow.
module dtec_timer (
	input wire logic clock, // System clock.
	input wire logic resetn, // Synchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write direction.
	input wire logic [dtec_pkg::DTEC_ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [dtec_pkg::DTEC_DATA_W-1:0] pwdata, // APB write data.
	output logic [dtec_pkg::DTEC_DATA_W-1:0] prdata, // APB read data.
	output logic pready, // APB transfer done.
	output logic pslverr, // APB error for an unmapped address.
	input wire logic [1:0] count_pin_in, // Levels of count_pin_zero and count_pin_one.
	output logic [1:0] count_pin_out, // Toggle output levels of the count pins.
	output logic [1:0] count_pin_oe, // Count pin drive enables.
	input wire logic [1:0] gate_pin, // Levels of gate_pin_zero and gate_pin_one.
	output logic irq // Interrupt, high while an unmasked flag is set.
);

	localparam logic [2:0] LAST_PHASE = 3'(dtec_pkg::DTEC_CLOCKS_PER_MCYCLE - 1);

	// Registered state and the next values computed for it.
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic mcycle_tick;
	logic [1:0] sample_prev;
	logic [1:0] next_sample_prev;
	logic [1:0] falling;
	logic [7:0] mode_reg;
	logic [7:0] next_mode_reg;
	logic [3:0] control;
	logic [3:0] next_control;
	logic [1:0] status;
	logic [1:0] next_status;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [1:0] toggle;
	logic [1:0] next_toggle;
	dtec_pkg::dtec_count_t cnt [2];
	dtec_pkg::dtec_count_t next_cnt [2];
	logic [dtec_pkg::DTEC_DATA_W-1:0] next_prdata;
	logic next_pslverr;

	// Per-unit decode of the mode and control registers.
	logic [1:0] run;
	logic [1:0] toggle_en;
	logic [1:0] gate_bit;
	logic [1:0] source_bit;
	dtec_pkg::dtec_mode_t mode [2];
	logic [1:0] unit_inc;
	logic [1:0] events;
	logic split0;
	logic high0_inc;
	dtec_pkg::dtec_step_t step [2];

	// Bus decode.
	logic setup;
	logic access_wr;
	logic [7:0] idx;
	logic idx_ok;
	logic hit_control;
	logic hit_mode;
	logic hit_status;
	logic hit_mask;
	logic [3:0] hit_count;

	// Advances one unit by one count in the given mode. In split mode only the low byte
	// moves; the high byte of timer 0 is stepped separately.
	function automatic dtec_pkg::dtec_step_t dtec_step(dtec_pkg::dtec_count_t c,
		dtec_pkg::dtec_mode_t m, logic inc);
		dtec_pkg::dtec_step_t r;
		logic [12:0] p;
		r.ovf = 1'b0;
		r.count = c;
		p = {c.count_high_byte, c.count_low_byte[4:0]};
		if (inc) begin
			unique case (m)
				dtec_pkg::DTEC_MODE_PRESCALED13: begin
					// The upper three low-byte bits keep whatever software wrote.
					r.ovf = (p == dtec_pkg::DTEC_PRESCALED_ONES);
					p = p + 13'h0001;
					r.count.count_high_byte = p[12:5];
					r.count.count_low_byte[4:0] = p[4:0];
				end
				dtec_pkg::DTEC_MODE_CASCADED16: begin
					r.ovf = (c == 16'hffff);
					r.count = c + 16'h0001;
				end
				dtec_pkg::DTEC_MODE_AUTO_RELOAD: begin
					// The high byte is only read here, so the reload value survives.
					r.ovf = (c.count_low_byte == dtec_pkg::DTEC_BYTE_ONES);
					r.count.count_low_byte = r.ovf ? c.count_high_byte :
						c.count_low_byte + 8'h01;
				end
				dtec_pkg::DTEC_MODE_SPLIT: begin
					r.ovf = (c.count_low_byte == dtec_pkg::DTEC_BYTE_ONES);
					r.count.count_low_byte = c.count_low_byte + 8'h01;
				end
			endcase
		end
		return r;
	endfunction

	assign run = control[dtec_pkg::DTEC_CTRL_RUN +: 2];
	assign toggle_en = control[dtec_pkg::DTEC_CTRL_TOGGLE +: 2];
	assign split0 = (mode[0] == dtec_pkg::DTEC_MODE_SPLIT);

	// Machine cycle divider.
	always_comb begin
		next_phase = mcycle_tick ? 3'h0 : phase + 3'h1;
	end

	assign mcycle_tick = (phase == LAST_PHASE);

	always_ff @(posedge clock) begin
		if (!resetn) begin
			// Phase zero after reset puts the first tick on the sixth edge after release.
			phase <= 3'h0;
		end else begin
			phase <= next_phase;
		end
	end

	// Count pin sampling, one sample per machine cycle.
	always_comb begin
		next_sample_prev = mcycle_tick ? count_pin_in : sample_prev;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			// A reset value of zero cannot fake a falling edge before the first sample.
			sample_prev <= 2'h0;
		end else begin
			sample_prev <= next_sample_prev;
		end
	end

	// Per-unit control decode and count enables.
	generate
		for (genvar u = 0; u < 2; u++) begin : g_unit
			// Timer 1 sits one field above timer 0 in the mode register.
			localparam int BASE = u * dtec_pkg::DTEC_MODE_UNIT_W;
			assign gate_bit[u] = mode_reg[BASE + dtec_pkg::DTEC_FLD_GATE];
			assign source_bit[u] = mode_reg[BASE + dtec_pkg::DTEC_FLD_SOURCE];
			assign mode[u] = dtec_pkg::dtec_mode_t'(mode_reg[BASE + dtec_pkg::DTEC_FLD_MODE +: 2]);
			// A sample high followed by a sample low is one event; the count moves at this
			// tick so the new value is seen in the following machine cycle.
			assign falling[u] = mcycle_tick & sample_prev[u] & ~count_pin_in[u];
			assign count_pin_out[u] = toggle[u];
			assign count_pin_oe[u] = toggle_en[u];
		end
	endgenerate

	// Timer 0 low byte always follows timer 0 controls; timer 1 halts in split mode.
	assign unit_inc[0] = run[0] & (~gate_bit[0] | gate_pin[0]) &
		(source_bit[0] ? falling[0] : mcycle_tick);
	assign unit_inc[1] = run[1] & (~gate_bit[1] | gate_pin[1]) &
		(source_bit[1] ? falling[1] : mcycle_tick) &
		(mode[1] != dtec_pkg::DTEC_MODE_SPLIT);
	// Split mode lends timer 1's run bit to timer 0's high byte, a plain machine-cycle timer.
	assign high0_inc = split0 & run[1] & mcycle_tick;

	// APB decode.
	assign setup = psel & ~penable;
	assign access_wr = psel & penable & pwrite & ~pslverr;
	// Byte lanes below a word are ignored; bits above the index field must be zero.
	assign idx = paddr[9:2];
	assign idx_ok = (paddr[dtec_pkg::DTEC_ADDR_W-1:10] == 2'h0);
	assign hit_control = idx_ok & (idx == dtec_pkg::DTEC_IDX_CONTROL);
	assign hit_mode = idx_ok & (idx == dtec_pkg::DTEC_IDX_MODE);
	assign hit_status = idx_ok & (idx == dtec_pkg::DTEC_IDX_STATUS);
	assign hit_mask = idx_ok & (idx == dtec_pkg::DTEC_IDX_MASK);
	assign hit_count[0] = idx_ok & (idx == dtec_pkg::DTEC_IDX_LOW0);
	assign hit_count[1] = idx_ok & (idx == dtec_pkg::DTEC_IDX_HIGH0);
	assign hit_count[2] = idx_ok & (idx == dtec_pkg::DTEC_IDX_LOW1);
	assign hit_count[3] = idx_ok & (idx == dtec_pkg::DTEC_IDX_HIGH1);
	// No wait states: the answer is ready in the access cycle itself.
	assign pready = psel & penable;

	// Counting, overflow events and the count bytes.
	always_comb begin
		logic high0_ovf;
		high0_ovf = 1'b0;
		// Each unit steps in its own mode; timer 1 is held in split mode by its enable.
		step[0] = dtec_step(cnt[0], mode[0], unit_inc[0]);
		step[1] = dtec_step(cnt[1], mode[1], unit_inc[1]);
		next_cnt[0] = step[0].count;
		next_cnt[1] = step[1].count;
		if (high0_inc) begin
			high0_ovf = (cnt[0].count_high_byte == dtec_pkg::DTEC_BYTE_ONES);
			next_cnt[0].count_high_byte = cnt[0].count_high_byte + 8'h01;
		end
		// In split mode the flag of timer 1 belongs to the high byte of timer 0.
		events[0] = step[0].ovf;
		events[1] = split0 ? high0_ovf : step[1].ovf;
		// A software write to a count byte takes precedence over counting in that cycle.
		if (access_wr && hit_count[0]) begin
			next_cnt[0].count_low_byte = pwdata[7:0];
		end
		if (access_wr && hit_count[1]) begin
			next_cnt[0].count_high_byte = pwdata[7:0];
		end
		if (access_wr && hit_count[2]) begin
			next_cnt[1].count_low_byte = pwdata[7:0];
		end
		if (access_wr && hit_count[3]) begin
			next_cnt[1].count_high_byte = pwdata[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			// Counts start at zero; software loads them before it sets a run bit.
			cnt[0] <= '0;
			cnt[1] <= '0;
		end else begin
			cnt[0] <= next_cnt[0];
			cnt[1] <= next_cnt[1];
		end
	end

	// Toggle outputs sit at one while disabled, so each enable starts from one. The enable
	// taking effect at this edge is used, so a drive turning off finds the level high.
	always_comb begin
		logic [1:0] next_en;
		logic [1:0] flip;
		next_en = next_control[dtec_pkg::DTEC_CTRL_TOGGLE +: 2];
		flip = toggle_en & {step[1].ovf, step[0].ovf};
		next_toggle[0] = next_en[0] ? toggle[0] ^ flip[0] : 1'b1;
		next_toggle[1] = next_en[1] ? toggle[1] ^ flip[1] : 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			toggle <= 2'h3;
		end else begin
			toggle <= next_toggle;
		end
	end

	// Software registers; an overflow in the clearing cycle keeps its flag set.
	always_comb begin
		next_mode_reg = mode_reg;
		next_control = control;
		next_mask = mask;
		next_status = status | events;
		if (access_wr && hit_mode) begin
			next_mode_reg = pwdata[7:0];
		end
		if (access_wr && hit_control) begin
			next_control = pwdata[3:0];
		end
		if (access_wr && hit_mask) begin
			next_mask = pwdata[1:0];
		end
		if (access_wr && hit_status) begin
			next_status = (status & ~pwdata[1:0]) | events;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			// Gate off, timer function and mode 00 in both units.
			mode_reg <= dtec_pkg::DTEC_MODE_RESET;
			control <= dtec_pkg::DTEC_CTRL_RESET;
			mask <= 2'h0;
			status <= 2'h0;
		end else begin
			mode_reg <= next_mode_reg;
			control <= next_control;
			mask <= next_mask;
			status <= next_status;
		end
	end

	// A level output: it falls only when software clears the flag or masks it.
	assign irq = |(status & mask);

	// Read data and error are captured in the setup cycle and stand through the access phase.
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_prdata = '0;
			next_pslverr = 1'b0;
			if (hit_control) begin
				next_prdata[3:0] = control;
			end else if (hit_mode) begin
				next_prdata[7:0] = mode_reg;
			end else if (hit_status) begin
				next_prdata[1:0] = status;
			end else if (hit_mask) begin
				next_prdata[1:0] = mask;
			end else if (hit_count[0]) begin
				next_prdata[7:0] = cnt[0].count_low_byte;
			end else if (hit_count[1]) begin
				next_prdata[7:0] = cnt[0].count_high_byte;
			end else if (hit_count[2]) begin
				next_prdata[7:0] = cnt[1].count_low_byte;
			end else if (hit_count[3]) begin
				next_prdata[7:0] = cnt[1].count_high_byte;
			end else begin
				next_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

// *** verification/dtec_assertions.sv ***
/* Port checker for the dual timer/event counter.
 Assumes it is bound into dtec_timer and sees only its ports. */
`timescale 1ns/1ps
module dtec_checker (
	input wire logic clock, // Clock.
	input wire logic resetn, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Access.
	input wire logic pwrite, // Direction.
	input wire logic [dtec_pkg::DTEC_ADDR_W-1:0] paddr, // Address.
	input wire logic [dtec_pkg::DTEC_DATA_W-1:0] pwdata, // Write data.
	input wire logic [dtec_pkg::DTEC_DATA_W-1:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic [1:0] count_pin_in, // Pin levels.
	input wire logic [1:0] count_pin_out, // Toggle levels.
	input wire logic [1:0] count_pin_oe, // Drive enables.
	input wire logic [1:0] gate_pin, // Gate levels.
	input wire logic irq // Interrupt.
);
	wire logic unmapped = paddr[11:10] != 2'b00 || paddr[9:5] != 5'h11;
	wire logic acc_wr = psel && penable && pwrite;
	wire logic ctl_wr = acc_wr && paddr == {2'b00, dtec_pkg::DTEC_IDX_CONTROL, 2'b00};
	wire logic msk_wr = acc_wr && paddr == {2'b00, dtec_pkg::DTEC_IDX_MASK, 2'b00};
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_ready_access: assert property (pready == (psel && penable))
		else $error("pready does not follow the access phase");
	chk_unmapped_err: assert property (psel && !penable && unmapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (psel && !penable && !unmapped |=> !pslverr)
		else $error("mapped access refused");
	chk_read_stands: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
		else $error("read answer changed after access");
	chk_toggle_enable: assert property (ctl_wr |=> count_pin_oe == $past(pwdata[3:2]))
		else $error("drive enable does not follow control write");
	chk_idle_high: assert property ((count_pin_out | count_pin_oe) == 2'b11)
		else $error("undriven toggle output not high");
	chk_toggle_spacing: assert property ($changed(count_pin_out[0]) && count_pin_oe[0] |=>
		(!count_pin_oe[0] || $stable(count_pin_out[0]))[*5])
		else $error("toggles closer than a machine cycle");
	chk_mask_quiet: assert property (msk_wr && pwdata[1:0] == 2'b00 |=> !irq)
		else $error("interrupt high with all flags masked");
endmodule

bind dtec_timer dtec_checker dtec_checker_i (.clock(clock), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .count_pin_in(count_pin_in),
	.count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe), .gate_pin(gate_pin), .irq(irq));

// *** verification/dtec_pins.sv ***
/* Outside world of the timer: count pin and gate pin sources.
 Assumes the bench resolves each count pin against the block's drive. */
`timescale 1ns/1ps
module dtec_pins (
	input wire logic clock, // Clock.
	output logic [1:0] level, // Count pin sources.
	output logic [1:0] gate // Gate pin levels.
);
	// Pin one rests on its pull-up; pin zero carries the events.
	initial begin
		level = 2'b11;
		gate = 2'b00;
	end
	task automatic hold();
		repeat ($urandom_range(6, 11)) @(posedge clock);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			level[0] <= 1'b1;
			hold();
			level[0] <= 1'b0;
			hold();
		end
	endtask
	task automatic gate_to(input logic [1:0] g);
		gate <= g;
	endtask
endmodule

// *** verification/dtec_timer_test.sv ***
/* Self-checking bench for the dual timer/event counter.
 Assumes the checker is bound in and dtec_pins drives the pins. */
`timescale 1ns/1ps
module dtec_timer_test;
	logic clock, resetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [dtec_pkg::DTEC_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] pin_in, pin_out, pin_oe, lvl, gate;
	int n_fail = 0, n_tests = 0, cyc = 0, tmo = 0, e;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
	dtec_timer dtec_timer_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_pin_in(pin_in), .count_pin_out(pin_out),
		.count_pin_oe(pin_oe), .gate_pin(gate), .irq(irq));
	dtec_pins dtec_pins_i (.clock(clock), .level(lvl), .gate(gate));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Edge number since reset release; a tick falls on every sixth.
	always @(posedge clock) begin
		cyc <= resetn ? cyc + 1 : 0;
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		e = cyc + 1;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	function automatic void adv(inout int lo, inout int hi, input int m, input int n, inout int o);
		int p;
		repeat (n) begin
			case (m)
				0: begin
					p = (hi * 32 + lo % 32 + 1) % 8192;
					o += (p == 0);
					hi = p / 32;
					lo = lo / 32 * 32 + p % 32;
				end
				1: begin
					p = (hi * 256 + lo + 1) % 65536;
					o += (p == 0);
					hi = p / 256;
					lo = p % 256;
				end
				2: begin
					o += (lo == 255);
					lo = (lo == 255) ? hi : lo + 1;
				end
				default: begin
					o += (lo == 255);
					lo = (lo + 1) % 256;
				end
			endcase
		end
	endfunction
	task automatic run_case(input logic [7:0] md, input logic [1:0] tg, input logic [1:0] gp,
		input int nev);
		int r[4];
		int o[2];
		int e0, t, n, m, i, x;
		logic [1:0] mk, st;
		mk = 2'($urandom_range(0, 3));
		apb(1'b1, dtec_pkg::DTEC_IDX_MASK, 32'(mk));
		apb(1'b1, dtec_pkg::DTEC_IDX_STATUS, 32'h3);
		apb(1'b1, dtec_pkg::DTEC_IDX_MODE, 32'(md));
		for (i = 0; i < 4; i++) begin
			m = md[i / 2 * 4 +: 2];
			r[i] = i % 2 == 0 ? 255 - $urandom_range(0, 40) : (m < 2 ? 255 : $urandom_range(0, 255));
			apb(1'b1, dtec_pkg::DTEC_IDX_LOW0 + 8'(i), 32'(r[i]));
		end
		dtec_pins_i.gate_to(gp);
		apb(1'b1, dtec_pkg::DTEC_IDX_CONTROL, {28'h0, tg, 2'b11});
		e0 = e;
		if (nev > 0) begin
			dtec_pins_i.pulse(nev);
			repeat (12) @(posedge clock);
		end else begin
			repeat ($urandom_range(200, 500)) @(posedge clock);
		end
		apb(1'b1, dtec_pkg::DTEC_IDX_CONTROL, {28'h0, tg, 2'b00});
		t = e / 6 - e0 / 6;
		o = '{0, 0};
		for (i = 0; i < 2; i++) begin
			m = md[i * 4 +: 2];
			n = md[i * 4 + 2] ? (i == 0 ? nev : 0) : t;
			if (md[i * 4 + 3] && !gp[i]) n = 0;
			if (m != 3 || i == 0) adv(r[2 * i], r[2 * i + 1], m, n, o[i]);
		end
		if (md[1:0] == 2'b11) adv(r[1], x, 3, t, o[1]);
		st = {o[1] > 0, o[0] > 0};
		chk("pin_out", {30'h0, tg[1] ? ~o[1][0] : 1'b1, tg[0] ? ~o[0][0] : 1'b1}, 32'(pin_out));
		for (i = 0; i < 4; i++) begin
			apb(1'b0, dtec_pkg::DTEC_IDX_LOW0 + 8'(i), 32'h0);
			chk("count", r[i], q);
		end
		apb(1'b0, dtec_pkg::DTEC_IDX_STATUS, 32'h0);
		chk("status", 32'(st), q);
		chk("irq", 32'(|(st & mk)), 32'(irq));
		apb(1'b1, dtec_pkg::DTEC_IDX_STATUS, 32'h3);
		apb(1'b1, dtec_pkg::DTEC_IDX_CONTROL, 32'h0);
		chk("irq_clear", 32'h0, 32'(irq));
		$display("case with mode %h done", md);
	endtask
	initial begin
		int k;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		resetn = 1'b0;
		k = $urandom(24);
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		apb(1'b0, dtec_pkg::DTEC_IDX_MODE, 32'h0);
		chk("mode_reset", 32'h0, q);
		apb(1'b0, 8'h90, 32'h0);
		chk("unmapped", 32'h1, 32'(er));
		apb(1'b1, dtec_pkg::DTEC_IDX_MASK, 32'h0);
		k = $urandom_range(0, 255);
		apb(1'b1, dtec_pkg::DTEC_IDX_MODE, 32'(k));
		apb(1'b0, dtec_pkg::DTEC_IDX_MODE, 32'h0);
		chk("mode", 32'(k), q);
		$display("register case done");
		run_case(8'h10, 2'b11, 2'b00, 0);
		run_case(8'h92, 2'b01, 2'b00, 0);
		run_case(8'h92, 2'b01, 2'b10, 0);
		run_case(8'h33, 2'b01, 2'b00, 0);
		run_case(8'h2d, 2'b10, 2'b01, $urandom_range(3, 9));
		run_case(8'h04, 2'b00, 2'b00, 5);
		close_out();
	end
endmodule
